// file: hdl/att_pkg.sv
// constants, register layouts and bus carriers of the trigger/timing block
// assumes an AXI4-Lite master with 32-bit data and one clock domain
`default_nettype none
package att_pkg;
    // widths and counts
    localparam int ADDR_W = 8;
    localparam int NPFI = 8;
    localparam int NDIO = 2;
    localparam int SEL_W = 4;
    localparam int VEC_W = 16;
    localparam int CNT_W = 16;
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_SRC = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_DIV = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_DLY = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_STAT = 8'h10;
    // reset values
    localparam logic [31:0] RST_CTRL = 32'h0000_0000;
    localparam logic [31:0] RST_SRC = 32'h0000_0000;
    localparam logic [CNT_W-1:0] RST_DIV = 16'h0002;
    localparam logic [CNT_W-1:0] RST_DLY = 16'h0000;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // source select codes, index into the synchronised source vector
    localparam logic [SEL_W-1:0] SRC_HOST = 4'h0;
    localparam logic [SEL_W-1:0] SRC_IN_REF = 4'h1;
    localparam logic [SEL_W-1:0] SRC_IN_LAUNCH = 4'h2;
    localparam logic [SEL_W-1:0] SRC_ANALOG = 4'h3;
    localparam logic [SEL_W-1:0] SRC_DIO0 = 4'h4;
    localparam logic [SEL_W-1:0] SRC_DIO1 = 4'h5;
    localparam logic [SEL_W-1:0] SRC_PFI0 = 4'h8;
    // sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ARMED = 4'h2,
        ST_DELAY = 4'h4,
        ST_RUN = 4'h8
    } att_state_e;
    // control register, bits 0..2 are write-only pulses
    typedef struct packed {
        logic [20:0] rsvd;
        logic launchUseTrig;
        logic pulseLow;
        logic strobeFall;
        logic holdActLow;
        logic holdEn;
        logic launchFall;
        logic baseExt;
        logic strobeExt;
        logic hostPulse;
        logic stop;
        logic go;
    } att_ctrl_s;
    // source select and terminal routing register
    typedef struct packed {
        logic [7:0] rsvd;
        logic lnchRouteEn;
        logic [2:0] lnchTerm;
        logic strbRouteEn;
        logic [2:0] strbTerm;
        logic [SEL_W-1:0] baseSel;
        logic [SEL_W-1:0] strbSel;
        logic [SEL_W-1:0] holdSel;
        logic [SEL_W-1:0] launchSel;
    } att_src_s;
    // status register
    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic [11:0] rsvd;
        logic holding;
        logic running;
        logic delaying;
        logic armed;
    } att_stat_s;
    // AXI4-Lite master to slave
    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [ADDR_W-1:0] araddr;
        logic arvalid;
        logic rready;
    } att_axi_req_s;
    // AXI4-Lite slave to master
    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } att_axi_rsp_s;
endpackage
`default_nettype wire

// file: hdl/att_sync_edge.sv
// two-flop synchroniser with edge detect on a third flop
// assumes inputs may be asynchronous to ref_clk
`default_nettype none
module att_sync_edge #(
    parameter int W = 16
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // raw inputs
    input wire logic [W-1:0] d,
    // synchronised level and one-cycle edges
    output logic [W-1:0] lvl,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    // all state of the synchroniser
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } att_sync_s;

    att_sync_s st_reg;
    att_sync_s st_next;

    // shift chain; s1 feeds only s2
    always_comb
    begin
        st_next.s1 = d;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
    end

    // synchronous reset to all zero
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    // edges compare the second and third stages only
    assign lvl = st_reg.s2;
    assign rise = st_reg.s2 & ~st_reg.s3;
    assign fall = ~st_reg.s2 & st_reg.s3;
endmodule
`default_nettype wire

// file: hdl/att_trig_timing.sv
// output update strobe, launch and hold sequencing with AXI4-Lite registers
// assumes one 50 MHz ref_clk, synchronous active-low reset, async pins
//
// Contract
// R1: every channel updates on each strobe together
// R2: strobe source internal or external, configurable
// R3: strobe routable to terminals, active high default
// R4: strobe divided from internal or external timebase
// R5: timebase never routed to any terminal
// R6: start on launch event or software command
// R7: programmable launch-to-first-sample delay, internal strobe
// R8: launch source and active edge selectable
// R9: analog event launches on selected edge
// R10: host configures analog threshold via input task
// R11: routed launch event is active-high pulse
// R12: hold suppresses next samples, current completes
// R13: onboard strobe resumes at once after hold
// R14: external strobe resumes on next edge after hold
// R15: hold source and active level configurable
// R16: analog event holds at configured level
// R17: digital triggers from two input slots
// R18: hold responds to level, never edges
// R19: synchronise launch and hold inputs first
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`default_nettype none
module att_trig_timing #(
    parameter int CH = 4
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // register bus
    input wire att_pkg::att_axi_req_s axiReq,
    output var att_pkg::att_axi_rsp_s axiRsp,
    // trigger, gate and clock sources
    input wire logic [att_pkg::NPFI-1:0] pfiIn,
    input wire logic [att_pkg::NDIO-1:0] dioTrig,
    input wire logic inRefEvent,
    input wire logic inLaunchEvent,
    input wire logic analogEvent,
    // programmable terminal drivers
    output var logic [att_pkg::NPFI-1:0] pfiOut,
    output var logic [att_pkg::NPFI-1:0] pfiOeN,
    // channel update and event pulses
    output var logic [CH-1:0] chanUpdate,
    output var logic updateStrobe,
    output var logic launchPulse
);
    import att_pkg::*;

    // all state of the block
    typedef struct packed {
        att_state_e fsm;
        att_ctrl_s ctrl;
        att_src_s src;
        logic [CNT_W-1:0] div;
        logic [CNT_W-1:0] dly;
        logic [CNT_W-1:0] divCnt;
        logic [CNT_W-1:0] dlyCnt;
        logic [CNT_W-1:0] count;
        logic strobe;
        logic launch;
        logic holding;
        logic [CH-1:0] chan;
        logic awHave;
        logic wHave;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        att_axi_rsp_s rsp;
        logic [NPFI-1:0] pOut;
        logic [NPFI-1:0] pOeN;
    } att_top_s;

    att_top_s s_reg;
    att_top_s s_next;

    // raw source vector: host slot 0, spare 6..7 read as zero
    logic [VEC_W-1:0] rawVec;
    // synchronised levels and edges of every source
    logic [VEC_W-1:0] lvlVec;
    logic [VEC_W-1:0] riseVec;
    logic [VEC_W-1:0] fallVec;
    // decoded events of the current cycle
    logic goCmd;
    logic stopCmd;
    logic hostCmd;
    logic launchTrig;
    logic holdNow;
    logic extEdge;
    logic baseTick;
    logic divLast;
    logic fire;
    logic launchFire;
    logic [31:0] merged;
    att_stat_s stat;

    // both digital input slots feed the same select space
    assign rawVec = {pfiIn, 2'b00, dioTrig, analogEvent, inLaunchEvent,
        inRefEvent, 1'b0}; // R17

    // every external source passes two flops before any use
    att_sync_edge #(
        .W(VEC_W)
    ) u_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .d(rawVec),
        .lvl(lvlVec),
        .rise(riseVec),
        .fall(fallVec)
    ); // R19

    // pick one source out of a synchronised vector
    function automatic logic pick(input logic [SEL_W-1:0] sel,
        input logic [VEC_W-1:0] v);
        return v[sel];
    endfunction

    // apply byte enables of a write to an old register value
    function automatic logic [31:0] mergeBytes(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
                r[8*b +: 8] = nw[8*b +: 8];
        end
        return r;
    endfunction

    // status word seen by software
    always_comb
    begin
        stat = '0;
        stat.count = s_reg.count;
        stat.holding = s_reg.holding;
        stat.running = (s_reg.fsm == ST_RUN);
        stat.delaying = (s_reg.fsm == ST_DELAY);
        stat.armed = (s_reg.fsm == ST_ARMED);
    end

    // trigger decoding from the selected sources
    always_comb
    begin
        // host pulse or edge of any other source, edge selectable
        if (s_reg.src.launchSel == SRC_HOST)
            launchTrig = hostCmd; // R8
        else
            launchTrig = pick(s_reg.src.launchSel,
                s_reg.ctrl.launchFall ? fallVec : riseVec); // R8 R9
        // hold looks at a level only, polarity selectable
        holdNow = s_reg.ctrl.holdEn &&
            (pick(s_reg.src.holdSel, lvlVec) ^ s_reg.ctrl.holdActLow);
        // R15 R16 R18
        // external strobe edge, rising or falling
        extEdge = pick(s_reg.src.strbSel,
            s_reg.ctrl.strobeFall ? fallVec : riseVec); // R2
        // timebase is ref_clk itself or an external rising edge
        baseTick = s_reg.ctrl.baseExt ?
            pick(s_reg.src.baseSel, riseVec) : 1'b1; // R4
        // terminal count of the divider, divisor 0 acts as 1
        divLast = ({1'b0, s_reg.divCnt} + (CNT_W+1)'(1)) >=
            {1'b0, s_reg.div}; // R4
    end

    // next-state logic of bus slave and sequencer
    always_comb
    begin
        s_next = s_reg;
        goCmd = 1'b0;
        stopCmd = 1'b0;
        hostCmd = 1'b0;
        fire = 1'b0;
        launchFire = 1'b0;
        merged = mergeBytes(32'h0000_0000, s_reg.wdata, s_reg.wstrb);
        // write address and data are taken independently
        if (axiReq.awvalid && s_reg.rsp.awready)
        begin
            s_next.awHave = 1'b1;
            s_next.awaddr = axiReq.awaddr;
        end
        if (axiReq.wvalid && s_reg.rsp.wready)
        begin
            s_next.wHave = 1'b1;
            s_next.wdata = axiReq.wdata;
            s_next.wstrb = axiReq.wstrb;
        end
        // both halves present: perform the write and answer
        if (s_reg.awHave && s_reg.wHave && !s_reg.rsp.bvalid)
        begin
            s_next.awHave = 1'b0;
            s_next.wHave = 1'b0;
            s_next.rsp.bvalid = 1'b1;
            s_next.rsp.bresp = RESP_OKAY;
            case (s_reg.awaddr)
                OFF_CTRL:
                begin
                    merged = mergeBytes(s_reg.ctrl, s_reg.wdata,
                        s_reg.wstrb);
                    s_next.ctrl = att_ctrl_s'(merged);
                    goCmd = s_next.ctrl.go;
                    stopCmd = s_next.ctrl.stop;
                    hostCmd = s_next.ctrl.hostPulse;
                    // command bits never stay set
                    s_next.ctrl.go = 1'b0;
                    s_next.ctrl.stop = 1'b0;
                    s_next.ctrl.hostPulse = 1'b0;
                    s_next.ctrl.rsvd = '0;
                end
                OFF_SRC:
                begin
                    merged = mergeBytes(s_reg.src, s_reg.wdata,
                        s_reg.wstrb);
                    s_next.src = att_src_s'(merged);
                    s_next.src.rsvd = '0;
                end
                OFF_DIV:
                begin
                    merged = mergeBytes({16'h0000, s_reg.div},
                        s_reg.wdata, s_reg.wstrb);
                    s_next.div = merged[CNT_W-1:0];
                end
                OFF_DLY:
                begin
                    merged = mergeBytes({16'h0000, s_reg.dly},
                        s_reg.wdata, s_reg.wstrb);
                    s_next.dly = merged[CNT_W-1:0];
                end
                // status is read-only, the write is dropped
                OFF_STAT:
                    s_next.rsp.bresp = RESP_OKAY;
                // unmapped address
                default:
                    s_next.rsp.bresp = RESP_SLVERR;
            endcase
        end
        // write response taken
        if (s_reg.rsp.bvalid && axiReq.bready)
            s_next.rsp.bvalid = 1'b0;
        // read data taken
        if (s_reg.rsp.rvalid && axiReq.rready)
            s_next.rsp.rvalid = 1'b0;
        // read address taken, data follows next cycle
        if (axiReq.arvalid && s_reg.rsp.arready)
        begin
            s_next.rsp.rvalid = 1'b1;
            s_next.rsp.rresp = RESP_OKAY;
            case (axiReq.araddr)
                OFF_CTRL:
                    s_next.rsp.rdata = s_reg.ctrl;
                OFF_SRC:
                    s_next.rsp.rdata = s_reg.src;
                OFF_DIV:
                    s_next.rsp.rdata = {16'h0000, s_reg.div};
                OFF_DLY:
                    s_next.rsp.rdata = {16'h0000, s_reg.dly};
                OFF_STAT:
                    s_next.rsp.rdata = stat;
                default:
                begin
                    s_next.rsp.rdata = 32'h0000_0000;
                    s_next.rsp.rresp = RESP_SLVERR;
                end
            endcase
        end
        // sequencer
        case (s_reg.fsm)
            // waiting for software
            ST_IDLE:
            begin
                if (goCmd)
                begin
                    if (s_next.ctrl.launchUseTrig)
                        s_next.fsm = ST_ARMED;
                    else
                        launchFire = 1'b1; // R6
                end
            end
            // waiting for the launch event
            ST_ARMED:
            begin
                if (launchTrig)
                    launchFire = 1'b1; // R6 R8
            end
            // launch-to-first-sample delay
            ST_DELAY:
            begin
                if (s_reg.dlyCnt <= CNT_W'(1))
                    s_next.fsm = ST_RUN; // R7
                else
                    s_next.dlyCnt = s_reg.dlyCnt - CNT_W'(1); // R7
            end
            // generating; hold is judged only where a sample starts
            ST_RUN:
            begin
                if (!s_reg.ctrl.strobeExt)
                begin
                    if (baseTick)
                    begin
                        if (!divLast)
                            s_next.divCnt = s_reg.divCnt + CNT_W'(1);
                        // R4
                        else if (!holdNow)
                            fire = 1'b1; // R12 R13
                    end
                end
                else if (extEdge && !holdNow)
                    fire = 1'b1; // R2 R12 R14
            end
            // unknown code recovers to idle
            default:
                s_next.fsm = ST_IDLE;
        endcase
        // launch: first sample at once or after the delay
        if (launchFire)
        begin
            s_next.dlyCnt = s_reg.dly;
            s_next.divCnt = s_reg.div - CNT_W'(1);
            if (!s_reg.ctrl.strobeExt && s_reg.dly != '0)
                s_next.fsm = ST_DELAY; // R7
            else
                s_next.fsm = ST_RUN;
        end
        // a fired sample restarts the divider
        if (fire)
        begin
            s_next.divCnt = '0;
            s_next.count = s_reg.count + CNT_W'(1);
        end
        // stop wins over any state change in the same cycle; strobe and launch pulses of that cycle still go out
        if (stopCmd)
            s_next.fsm = ST_IDLE;
        s_next.holding = holdNow && (s_reg.fsm == ST_RUN);
        s_next.strobe = fire;
        s_next.launch = launchFire;
        s_next.chan = {CH{fire}}; // R1
        // ready flags follow the next occupancy
        s_next.rsp.awready = !s_next.awHave && !s_next.rsp.bvalid;
        s_next.rsp.wready = !s_next.wHave && !s_next.rsp.bvalid;
        s_next.rsp.arready = !s_next.rsp.rvalid;
        // terminal drivers; the timebase has no route at all
        for (int k = 0; k < NPFI; k++)
        begin
            if (s_reg.src.strbRouteEn && s_reg.src.strbTerm == 3'(k))
            begin
                s_next.pOut[k] = fire ^ s_reg.ctrl.pulseLow; // R3 R5
                s_next.pOeN[k] = 1'b0;
            end
            else if (s_reg.src.lnchRouteEn &&
                s_reg.src.lnchTerm == 3'(k))
            begin
                s_next.pOut[k] = launchFire; // R11
                s_next.pOeN[k] = 1'b0;
            end
            else
            begin
                s_next.pOut[k] = 1'b0;
                s_next.pOeN[k] = 1'b1;
            end
        end
    end

    // state register with synchronous reset
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            s_reg <= '0;
            s_reg.fsm <= ST_IDLE;
            s_reg.ctrl <= att_ctrl_s'(RST_CTRL);
            s_reg.src <= att_src_s'(RST_SRC);
            s_reg.div <= RST_DIV;
            s_reg.dly <= RST_DLY;
            s_reg.rsp.awready <= 1'b1;
            s_reg.rsp.wready <= 1'b1;
            s_reg.rsp.arready <= 1'b1;
            s_reg.pOeN <= '1;
        end
        else
            s_reg <= s_next;
    end

    // outputs straight from the state register
    assign axiRsp = s_reg.rsp;
    assign pfiOut = s_reg.pOut;
    assign pfiOeN = s_reg.pOeN;
    assign chanUpdate = s_reg.chan;
    assign updateStrobe = s_reg.strobe;
    assign launchPulse = s_reg.launch;

    // checks on the sequencer and bus
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    a_gang_update: assert property ( // R1
        updateStrobe |-> (chanUpdate == {CH{1'b1}}))
        else $error("channels did not update together");

    a_idle_quiet: assert property ( // R6
        (s_reg.fsm == ST_IDLE) && !goCmd |=> !updateStrobe)
        else $error("strobe while idle");

    a_launch_once: assert property ( // R11
        launchFire |=> launchPulse ##1 !launchPulse)
        else $error("launch pulse not one cycle");

    a_delay_end: assert property ( // R7
        (s_reg.fsm == ST_DELAY) && (s_reg.dlyCnt == CNT_W'(1)) &&
        !stopCmd |=> (s_reg.fsm == ST_RUN))
        else $error("delay did not end on count one");

    a_hold_blocks: assert property ( // R12
        (s_reg.fsm == ST_RUN) && holdNow |=> !updateStrobe)
        else $error("sample while held");

    a_onboard_resume: assert property ( // R13
        (s_reg.fsm == ST_RUN) && !s_reg.ctrl.strobeExt &&
        !s_reg.ctrl.baseExt && s_reg.holding && !holdNow && divLast
        |=> updateStrobe)
        else $error("onboard strobe did not resume at once");

    a_ext_edge_only: assert property ( // R14
        (s_reg.fsm == ST_RUN) && s_reg.ctrl.strobeExt && !extEdge
        |=> !updateStrobe)
        else $error("external strobe fired without an edge");

    a_strobe_route: assert property ( // R3
        $rose(updateStrobe) && $past(s_reg.src.strbRouteEn) &&
        !$past(s_reg.ctrl.pulseLow, 1) |->
        pfiOut[$past(s_reg.src.strbTerm)] &&
        !pfiOeN[$past(s_reg.src.strbTerm)])
        else $error("routed strobe not driven high");

    a_arm_trigger: assert property ( // R8
        (s_reg.fsm == ST_ARMED) && launchTrig && !stopCmd
        |=> (s_reg.fsm != ST_ARMED) && launchPulse)
        else $error("launch trigger ignored while armed");

    a_bresp_hold: assert property (
        axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid &&
        $stable(axiRsp.bresp))
        else $error("write response dropped");
endmodule
`default_nettype wire

// file: testbench/att_src_model.sv
// far-side sources on the terminal pins: static levels and a gated clock
// assumes the bench sets pin levels and gates the clock between frames
`default_nettype none
module att_src_model
(
    // static pin levels and external clock gate
    input wire logic [7:0] pinLvl,
    input wire logic clkRun,
    // terminal pins seen by the block
    output logic [7:0] pfiIn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic extClk = 1'b0; // external strobe, stands low outside frames
    // five ref periods per cycle, toggling 5 ns off every sampling edge
    always
    begin
        #25 extClk = clkRun ? ~extClk : 1'b0;
        #25;
    end
    // pin 1 carries the external clock, the rest are plain levels
    assign pfiIn = pinLvl | {6'h00, extClk, 1'h0};
endmodule
`default_nettype wire

// file: testbench/tb.sv
// bench for the trigger and timing block: registers, launch, hold, strobe
// assumes att_src_model on the terminal pins and a 50 MHz bench clock
`default_nettype none
module tb;
    import att_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    // one table row: address, word written, word read back, response
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] w;
        logic [31:0] e;
        logic [1:0] rs;
    } att_row_s;
    localparam att_row_s ROWS [7] = '{
        '{OFF_CTRL, 32'hFFFF_FFF8, 32'h0000_07F8, RESP_OKAY},
        '{OFF_CTRL, 32'h0000_0002, 32'h0000_0000, RESP_OKAY},
        '{OFF_DIV, 32'hFFFF_0003, 32'h0000_0003, RESP_OKAY},
        '{OFF_DLY, 32'hABCD_0000, 32'h0000_0000, RESP_OKAY},
        '{OFF_STAT, 32'hFFFF_FFFF, 32'h0000_0000, RESP_OKAY},
        '{8'h20, 32'hFFFF_FFFF, 32'h0000_0000, RESP_SLVERR},
        '{OFF_SRC, 32'hFFDA_098B, 32'h00DA_098B, RESP_OKAY}
    };
    logic ref_clk = 1'b0; // bench clock
    logic rstn = 1'b0; // synchronous reset, active low
    // bus requests; response readies stay high throughout
    att_axi_req_s req = '{bready: 1'b1, rready: 1'b1, default: '0};
    att_axi_rsp_s rsp; // bus answers
    logic [7:0] pinLvl = 8'h00; // static pin levels
    logic clkRun = 1'b0; // external clock gate
    logic anaLvl = 1'b0; // threshold result of the input task's circuit
    logic [7:0] pfiIn, pfiOut, pfiOeN;
    logic [3:0] chanUpdate;
    logic updateStrobe, launchPulse;
    int errTotal = 0;
    int numChecks = 0;
    int nStrb = 0, nLnch = 0, nPin = 0, cyc = 0, lastS = 0, gap = 0;
    int s0, p0;
    logic pinPrev = 1'b0; // last sampled level of the clock pin
    logic [1:0] r;
    logic [31:0] d;
    always #10 ref_clk = ~ref_clk;
    att_trig_timing #(.CH(4)) u_dut (
        .ref_clk(ref_clk), .rstn(rstn), .axiReq(req), .axiRsp(rsp),
        .pfiIn(pfiIn), .dioTrig(2'h0), .inRefEvent(1'b0),
        .inLaunchEvent(1'b0), .analogEvent(anaLvl), .pfiOut(pfiOut),
        .pfiOeN(pfiOeN), .chanUpdate(chanUpdate),
        .updateStrobe(updateStrobe), .launchPulse(launchPulse)
    );
    att_src_model u_src (.pinLvl(pinLvl), .clkRun(clkRun), .pfiIn(pfiIn));
    task automatic chk(input string n, input logic [31:0] s,
                       input logic [31:0] e);
        numChecks++;
        if (s !== e)
        begin
            errTotal++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cy(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      output logic [1:0] rs);
        req.awaddr <= a;
        req.wdata <= v;
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (req.awvalid && rsp.awready)
                req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready)
                req.wvalid <= 1'b0;
        end
        while (rsp.bvalid !== 1'b1);
        rs = rsp.bresp;
    endtask
    // read: address held until taken, data taken with rvalid
    task automatic rd(input logic [7:0] a, output logic [31:0] v,
                      output logic [1:0] rs);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (req.arvalid && rsp.arready)
                req.arvalid <= 1'b0;
        end
        while (rsp.rvalid !== 1'b1);
        v = rsp.rdata;
        rs = rsp.rresp;
    endtask
    task automatic end_sim();
        if (errTotal == 0 && numChecks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // count strobes, launches and clock pin rises; watch lanes and pin
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        pinPrev <= pfiIn[1];
        if (pfiIn[1] && !pinPrev)
            nPin <= nPin + 1;
        if (launchPulse === 1'b1)
            nLnch <= nLnch + 1;
        if (updateStrobe === 1'b1)
        begin
            nStrb <= nStrb + 1;
            gap <= cyc - lastS;
            lastS <= cyc;
        end
        if (rstn)
            chk("lanes", {28'h0, chanUpdate}, {28'h0, {4{updateStrobe}}});
        if (pfiOeN[2] === 1'b0)
            chk("strobe pin", {31'h0, pfiOut[2]}, {31'h0, updateStrobe});
    end
    // main sequence
    initial
    begin
        cy(10);
        rstn <= 1'b1;
        cy(2);
        chk("pin enables", {24'h0, pfiOeN}, 32'h0000_00FF);
        for (int i = 0; i < 5; i++)
        begin
            rd(8'(4 * i), d, r);
            chk("reset value", d, (i == 2) ? 32'h2 : 32'h0);
        end
        foreach (ROWS[i])
        begin
            wr(ROWS[i].a, ROWS[i].w, r);
            chk("write resp", {30'h0, r}, {30'h0, ROWS[i].rs});
            rd(ROWS[i].a, d, r);
            chk("read data", d, ROWS[i].e);
            chk("read resp", {30'h0, r}, {30'h0, ROWS[i].rs});
        end
        // software launch, internal strobe divided by three
        wr(OFF_CTRL, 32'h0000_0001, r);
        cy(20);
        chk("launches", nLnch, 1);
        chk("strobe gap", gap, 3);
        chk("pin enables", {24'h0, pfiOeN}, 32'h0000_00DB);
        // hold on terminal 0 at high level, then release
        wr(OFF_CTRL, 32'h0000_0040, r);
        pinLvl[0] <= 1'b1;
        cy(5);
        s0 = nStrb;
        cy(20);
        chk("held strobes", nStrb, s0);
        pinLvl[0] <= 1'b0;
        cy(5);
        chk("resume", nStrb, s0 + 1);
        // stop ends the run
        wr(OFF_CTRL, 32'h0000_0002, r);
        cy(3);
        s0 = nStrb;
        cy(10);
        chk("after stop", nStrb, s0);
        // armed launch on the falling edge of terminal 3
        wr(OFF_CTRL, 32'h0000_0421, r);
        pinLvl[3] <= 1'b1;
        cy(8);
        chk("no launch on rise", nLnch, 1);
        pinLvl[3] <= 1'b0;
        cy(20);
        chk("launch on fall", nLnch, 2);
        // external strobe on terminal 1, hold enabled but inactive
        wr(OFF_CTRL, 32'h0000_0002, r);
        wr(OFF_CTRL, 32'h0000_0048, r);
        wr(OFF_CTRL, 32'h0000_0049, r);
        cy(2);
        s0 = nStrb;
        p0 = nPin;
        clkRun <= 1'b1;
        cy(50);
        clkRun <= 1'b0;
        cy(10);
        chk("edge strobes", nStrb - s0, nPin - p0);
        // held edges are dropped; release alone does not resume
        pinLvl[0] <= 1'b1;
        cy(3);
        s0 = nStrb;
        clkRun <= 1'b1;
        cy(30);
        clkRun <= 1'b0;
        cy(5);
        pinLvl[0] <= 1'b0;
        cy(10);
        chk("no resume without edge", nStrb, s0);
        clkRun <= 1'b1;
        cy(12);
        chk("resume on edge", {31'h0, nStrb > s0}, 32'h1);
        // analog event launches, first sample five cycles after the launch pulse
        wr(OFF_CTRL, 32'h0000_0002, r);
        wr(OFF_DLY, 32'h0000_0004, r);
        wr(OFF_SRC, 32'h00DA_0983, r);
        wr(OFF_CTRL, 32'h0000_0401, r);
        s0 = nStrb;
        anaLvl <= 1'b1;
        cy(9);
        chk("delayed first", nStrb, s0);
        cy(1);
        chk("first sample", nStrb, s0 + 1);
        end_sim();
    end
    // watchdog against a hung handshake
    initial
    begin
        cy(5000);
        errTotal++;
        end_sim();
    end
endmodule
`default_nettype wire
